// ===== core/scc_pkg.sv
`default_nettype none
package scc_pkg;
  localparam int unsigned CLK_FREQ_MHZ     = 250;
  localparam int unsigned SPD_CODE_W       = 9;
  localparam int unsigned DUTY_W           = 8;
  localparam int unsigned LEAD_W           = 8;
  localparam int unsigned SFS_W            = 5;
  localparam int unsigned RPM_W            = 16;
  localparam int unsigned MEAS_CNT_W       = 24;
  localparam int unsigned DIV_W            = 32;
  localparam int unsigned DUTY_SHIFT       = 8;
  localparam logic [7:0]  DUTY_FULL        = 8'hff;
  // timing
  localparam int unsigned MEAS_TIMEOUT_US  = 40000;
  localparam int unsigned MEAS_TIMEOUT_CYC = MEAS_TIMEOUT_US * CLK_FREQ_MHZ;
  localparam int unsigned CFG_SETTLE_NS    = 1000;
  localparam int unsigned CFG_SETTLE_CYC   = (CFG_SETTLE_NS * CLK_FREQ_MHZ + 999) / 1000;
  localparam int unsigned CARRIER_FREQ_KHZ = 48;
  localparam int unsigned CARRIER_CYC      = CLK_FREQ_MHZ * 1000 / CARRIER_FREQ_KHZ;
  localparam int unsigned CARRIER_W        = 13;
  localparam int unsigned DEAD_SHORT_NS    = 250;
  localparam int unsigned DEAD_LONG_NS     = 500;
  localparam int unsigned DEAD_SHORT_CYC   = (DEAD_SHORT_NS * CLK_FREQ_MHZ + 999) / 1000;
  localparam int unsigned DEAD_LONG_CYC    = (DEAD_LONG_NS * CLK_FREQ_MHZ + 999) / 1000;
  // speed lookup segments
  localparam int unsigned RPM_ZERO_LAST    = 5;
  localparam int unsigned SEG1_CODE        = 6;
  localparam int unsigned SEG1_BASE        = 400;
  localparam int unsigned SEG1_STEP        = 10;
  localparam int unsigned SEG2_CODE        = 73;
  localparam int unsigned SEG2_BASE        = 1080;
  localparam int unsigned SEG2_STEP        = 20;
  localparam int unsigned SEG3_CODE        = 148;
  localparam int unsigned SEG3_BASE        = 2600;
  localparam int unsigned SEG3_STEP        = 50;
  localparam int unsigned SEG4_CODE        = 201;
  localparam int unsigned SEG4_BASE        = 5300;
  localparam int unsigned SEG4_STEP        = 100;
  // register map
  localparam logic [7:0]  REG_CTRL         = 8'h00;
  localparam logic [7:0]  REG_DUTY         = 8'h04;
  localparam logic [7:0]  REG_TARGET       = 8'h08;
  localparam logic [7:0]  REG_LEAD         = 8'h0c;
  localparam logic [7:0]  REG_CONFIG       = 8'h10;
  localparam logic [7:0]  REG_POINTS       = 8'h14;
  localparam logic        CTRL_RESET       = 1'b1;
  localparam int unsigned DUTY_STATIC_BIT  = 8;
  localparam int unsigned DUTY_LEVEL_BIT   = 9;
  localparam int unsigned TGT_STOP_BIT     = 16;
  localparam int unsigned TGT_FULL_BIT     = 17;
  localparam int unsigned CFG_DEAD_BIT     = 4;
  localparam int unsigned CFG_DONE_BIT     = 8;
  localparam int unsigned PTS_HSP_LSB      = 16;

  typedef struct packed {
    logic [SPD_CODE_W-1:0] speed_a;
    logic [SPD_CODE_W-1:0] speed_b;
    logic [DUTY_W-1:0]     duty_x;
    logic [DUTY_W-1:0]     duty_z;
    logic [LEAD_W-1:0]     lead_lo;
    logic [LEAD_W-1:0]     lead_hi;
    logic [SFS_W-1:0]      softstart_deadtime_select_input;
  } scc_settings_s;

  typedef struct packed {
    logic leg1_hi;
    logic leg1_lo;
    logic leg2_hi;
    logic leg2_lo;
  } scc_gate_s;
endpackage
`default_nettype wire

// ===== core/scc_rpm_rom.sv
`timescale 1ns/100ps
`default_nettype none
module scc_rpm_rom (
  input  wire logic                             ref_clk,
  input  wire logic [scc_pkg::SPD_CODE_W-1:0]   addr,
  output var  logic [scc_pkg::RPM_W-1:0]        data_q
);
  function automatic logic [scc_pkg::RPM_W-1:0] rpm_of(input int unsigned c);
    int unsigned r;
    r = 0;
    if (c <= scc_pkg::RPM_ZERO_LAST) begin
      r = 0;
    end else if (c < scc_pkg::SEG2_CODE) begin
      r = scc_pkg::SEG1_BASE + scc_pkg::SEG1_STEP * (c - scc_pkg::SEG1_CODE);
    end else if (c < scc_pkg::SEG3_CODE) begin
      r = scc_pkg::SEG2_BASE + scc_pkg::SEG2_STEP * (c - scc_pkg::SEG2_CODE);
    end else if (c < scc_pkg::SEG4_CODE) begin
      r = scc_pkg::SEG3_BASE + scc_pkg::SEG3_STEP * (c - scc_pkg::SEG3_CODE);
    end else begin
      r = scc_pkg::SEG4_BASE + scc_pkg::SEG4_STEP * (c - scc_pkg::SEG4_CODE);
    end
    return r[scc_pkg::RPM_W-1:0];
  endfunction

  // registered read of the fixed monotonic table
  always_ff @(posedge ref_clk) begin
    data_q <= rpm_of(int'(addr));
  end
endmodule
`default_nettype wire

// ===== core/scc_divider.sv
`timescale 1ns/100ps
`default_nettype none
module scc_divider #(
  parameter int unsigned W = 32
) (
  input  wire logic         ref_clk,
  input  wire logic         arst_n,
  input  wire logic         start,
  input  wire logic [W-1:0] dividend,
  input  wire logic [W-1:0] divisor,
  output var  logic         done_q,
  output var  logic [W-1:0] quot_q
);
  localparam int unsigned CW = $clog2(W + 1);
  logic [W:0]    rem_q;
  logic [W-1:0]  den_q;
  logic [CW-1:0] cnt_q;
  logic          busy_q;
  logic [W:0]    sh;

  assign sh = {rem_q[W-1:0], quot_q[W-1]};

  // restoring division, one quotient bit per clock; zero divisor gives all ones
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      rem_q  <= '0;
      den_q  <= '0;
      quot_q <= '0;
      cnt_q  <= '0;
      busy_q <= 1'b0;
      done_q <= 1'b0;
    end else begin
      done_q <= 1'b0;
      if (start) begin
        rem_q  <= '0;
        den_q  <= divisor;
        quot_q <= dividend;
        cnt_q  <= CW'(W);
        busy_q <= 1'b1;
      end else if (busy_q) begin
        if (sh >= {1'b0, den_q}) begin
          rem_q  <= sh - {1'b0, den_q};
          quot_q <= {quot_q[W-2:0], 1'b1};
        end else begin
          rem_q  <= sh;
          quot_q <= {quot_q[W-2:0], 1'b0};
        end
        cnt_q <= cnt_q - CW'(1);
        if (cnt_q == CW'(1)) begin
          busy_q <= 1'b0;
          done_q <= 1'b1;
        end
      end
    end
  end
endmodule
`default_nettype wire

// ===== core/scc_speed_command_curve.sv
`timescale 1ns/100ps
`default_nettype none
module scc_speed_command_curve #(
  parameter int unsigned MEAS_TIMEOUT_CYC = scc_pkg::MEAS_TIMEOUT_CYC
) (
  input  wire logic                         ref_clk,
  input  wire logic                         arst_n,
  input  wire logic                         pwm_command_input,
  input  wire scc_pkg::scc_settings_s       setting_inputs,
  input  wire logic                         phase_select,
  input  wire logic                         wb_cyc_i,
  input  wire logic                         wb_stb_i,
  input  wire logic                         wb_we_i,
  input  wire logic [7:0]                   wb_adr_i,
  input  wire logic [3:0]                   wb_sel_i,
  input  wire logic [31:0]                  wb_dat_i,
  output var  logic [31:0]                  wb_dat_o,
  output var  logic                         wb_ack_o,
  output var  scc_pkg::scc_gate_s           gate_drive,
  output var  logic [scc_pkg::RPM_W-1:0]    target_rpm,
  output var  logic [scc_pkg::LEAD_W-1:0]   lead_angle,
  output var  logic                         motor_stop,
  output var  logic                         full_drive,
  output var  logic [3:0]                   softstart_pattern,
  output var  logic                         dead_time_long,
  output var  logic                         config_done
);
  localparam int unsigned CW = scc_pkg::MEAS_CNT_W;
  localparam int unsigned DW = scc_pkg::DIV_W;
  localparam int unsigned RW = scc_pkg::RPM_W;

  typedef enum logic [2:0] {CFG_SETTLE, CFG_RD_LO, CFG_RD_HI, CFG_FIN, CFG_DONE} scc_cfg_e;
  typedef enum logic [2:0] {C_IDLE, C_DUTY, C_MAP, C_SPD, C_LEAD} scc_calc_e;

  // ---------------- setting inputs: sync and one-time capture
  scc_pkg::scc_settings_s set_s1_q;
  scc_pkg::scc_settings_s set_s2_q;
  scc_pkg::scc_settings_s set_s3_q;
  scc_pkg::scc_settings_s cfg_q;
  scc_cfg_e               cfg_state_q;
  logic [9:0]             settle_cnt_q;
  logic [RW-1:0]          lsp_rpm_q;
  logic [RW-1:0]          hsp_rpm_q;
  logic [RW-1:0]          rom_data;
  logic [scc_pkg::SPD_CODE_W-1:0] spd_lo_code;
  logic [scc_pkg::SPD_CODE_W-1:0] spd_hi_code;
  logic [scc_pkg::SPD_CODE_W-1:0] rom_addr;
  logic [7:0]             duty_lo;
  logic [7:0]             duty_hi;
  logic                   stop_mode;
  logic                   free_mode;
  logic                   cfg_done;
  logic                   cfg_done_q;

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      set_s1_q <= '0;
      set_s2_q <= '0;
      set_s3_q <= '0;
    end else begin
      set_s1_q <= setting_inputs;
      set_s2_q <= set_s1_q;
      set_s3_q <= set_s2_q;
    end
  end

  // lower code is always the low point, so the curve cannot fall
  assign spd_lo_code = (cfg_q.speed_a > cfg_q.speed_b) ? cfg_q.speed_b : cfg_q.speed_a;
  assign spd_hi_code = (cfg_q.speed_a > cfg_q.speed_b) ? cfg_q.speed_a : cfg_q.speed_b;
  assign duty_lo     = (cfg_q.duty_x > cfg_q.duty_z) ? cfg_q.duty_z : cfg_q.duty_x;
  assign duty_hi     = (cfg_q.duty_x > cfg_q.duty_z) ? cfg_q.duty_x : cfg_q.duty_z;
  assign stop_mode   = cfg_q.speed_a > cfg_q.speed_b;
  assign free_mode   = cfg_q.duty_x > cfg_q.duty_z;
  assign rom_addr    = (cfg_state_q == CFG_RD_HI) ? spd_hi_code : spd_lo_code;
  assign cfg_done    = cfg_done_q;

  scc_rpm_rom u_rom (
    .ref_clk (ref_clk),
    .addr    (rom_addr),
    .data_q  (rom_data)
  );

  // capture once levels are stable, then never again until reset
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      cfg_state_q  <= CFG_SETTLE;
      settle_cnt_q <= '0;
      cfg_q        <= '0;
      lsp_rpm_q    <= '0;
      hsp_rpm_q    <= '0;
      cfg_done_q   <= 1'b0;
    end else begin
      case (cfg_state_q)
        CFG_SETTLE: begin
          if (set_s2_q != set_s3_q) begin
            settle_cnt_q <= '0;
          end else if (settle_cnt_q == 10'(scc_pkg::CFG_SETTLE_CYC - 1)) begin
            cfg_q       <= set_s3_q;
            cfg_state_q <= CFG_RD_LO;
          end else begin
            settle_cnt_q <= settle_cnt_q + 10'h001;
          end
        end
        CFG_RD_LO: cfg_state_q <= CFG_RD_HI;
        CFG_RD_HI: begin
          lsp_rpm_q   <= rom_data;
          cfg_state_q <= CFG_FIN;
        end
        CFG_FIN: begin
          hsp_rpm_q   <= rom_data;
          cfg_done_q  <= 1'b1;
          cfg_state_q <= CFG_DONE;
        end
        CFG_DONE: cfg_state_q <= CFG_DONE;
        default: cfg_state_q <= CFG_SETTLE;
      endcase
    end
  end

  // ---------------- command input: sync, filter, period and high time
  logic            pwm_s1_q;
  logic            pwm_s2_q;
  logic            pwm_s3_q;
  logic            pwm_f_q;
  logic            pwm_f_d;
  logic            pwm_rise;
  logic [CW-1:0]   high_cnt_q;
  logic [CW-1:0]   per_cnt_q;
  logic [CW-1:0]   high_lat_q;
  logic [CW-1:0]   per_lat_q;
  logic [CW-1:0]   idle_cnt_q;
  logic            seen_rise_q;
  logic            static_q;
  logic            static_lvl_q;
  logic            meas_upd_q;

  assign pwm_f_d  = (pwm_s2_q == pwm_s3_q) ? pwm_s3_q : pwm_f_q;
  assign pwm_rise = pwm_f_d & ~pwm_f_q;

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      pwm_s1_q <= 1'b0;
      pwm_s2_q <= 1'b0;
      pwm_s3_q <= 1'b0;
      pwm_f_q  <= 1'b0;
    end else begin
      pwm_s1_q <= pwm_command_input;
      pwm_s2_q <= pwm_s1_q;
      pwm_s3_q <= pwm_s2_q;
      pwm_f_q  <= pwm_f_d;
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      high_cnt_q   <= '0;
      per_cnt_q    <= '0;
      high_lat_q   <= '0;
      per_lat_q    <= '0;
      idle_cnt_q   <= '0;
      seen_rise_q  <= 1'b0;
      static_q     <= 1'b1;
      static_lvl_q <= 1'b0;
      meas_upd_q   <= 1'b0;
    end else begin
      meas_upd_q <= 1'b0;
      if (pwm_rise) begin
        high_cnt_q  <= '0;
        per_cnt_q   <= '0;
        seen_rise_q <= 1'b1;
        if (seen_rise_q) begin
          high_lat_q <= high_cnt_q;
          per_lat_q  <= per_cnt_q + CW'(1);
          meas_upd_q <= 1'b1;
          static_q   <= 1'b0;
        end
      end else begin
        per_cnt_q  <= per_cnt_q + CW'(1);
        high_cnt_q <= high_cnt_q + CW'(pwm_f_q);
      end
      if (pwm_f_d != pwm_f_q) begin
        idle_cnt_q <= '0;
      end else if (idle_cnt_q == CW'(MEAS_TIMEOUT_CYC - 1)) begin
        idle_cnt_q   <= '0;
        static_q     <= 1'b1;
        static_lvl_q <= pwm_f_q;
        seen_rise_q  <= 1'b0;
        meas_upd_q   <= 1'b1;
      end else begin
        idle_cnt_q <= idle_cnt_q + CW'(1);
      end
    end
  end

  // ---------------- duty, curve and lead angle arithmetic
  scc_calc_e        calc_q;
  logic [7:0]       duty_q;
  logic             div_start_q;
  logic [DW-1:0]    div_a_q;
  logic [DW-1:0]    div_b_q;
  logic             div_done;
  logic [DW-1:0]    div_quot;
  logic [RW-1:0]    target_q;
  logic [7:0]       lead_q;
  logic             stop_q;
  logic             full_q;
  logic [7:0]       lead_span;
  logic [7:0]       duty_ofs;
  logic [7:0]       duty_span;

  assign lead_span = (cfg_q.lead_lo <= cfg_q.lead_hi) ? cfg_q.lead_hi - cfg_q.lead_lo
                                                      : cfg_q.lead_lo - cfg_q.lead_hi;
  assign duty_ofs  = duty_q - duty_lo;
  assign duty_span = duty_hi - duty_lo;

  scc_divider #(
    .W (DW)
  ) u_div (
    .ref_clk  (ref_clk),
    .arst_n   (arst_n),
    .start    (div_start_q),
    .dividend (div_a_q),
    .divisor  (div_b_q),
    .done_q   (div_done),
    .quot_q   (div_quot)
  );

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      calc_q      <= C_IDLE;
      duty_q      <= '0;
      div_start_q <= 1'b0;
      div_a_q     <= '0;
      div_b_q     <= '0;
      target_q    <= '0;
      lead_q      <= '0;
      stop_q      <= 1'b1;
      full_q      <= 1'b0;
    end else begin
      div_start_q <= 1'b0;
      case (calc_q)
        C_IDLE: begin
          if (meas_upd_q && cfg_done) begin
            if (static_q) begin
              duty_q <= static_lvl_q ? scc_pkg::DUTY_FULL : 8'h00;
              calc_q <= C_MAP;
            end else begin
              div_a_q     <= {high_lat_q, 8'h00};
              div_b_q     <= DW'(per_lat_q);
              div_start_q <= 1'b1;
              calc_q      <= C_DUTY;
            end
          end
        end
        C_DUTY: begin
          if (div_done) begin
            duty_q <= (div_quot > DW'(scc_pkg::DUTY_FULL)) ? scc_pkg::DUTY_FULL
                                                           : div_quot[7:0];
            calc_q <= C_MAP;
          end
        end
        C_MAP: begin
          if (duty_q < duty_lo) begin
            stop_q   <= stop_mode;
            full_q   <= 1'b0;
            target_q <= stop_mode ? '0 : lsp_rpm_q;
            lead_q   <= cfg_q.lead_lo;
            calc_q   <= C_IDLE;
          end else if (duty_q > duty_hi) begin
            stop_q   <= 1'b0;
            full_q   <= free_mode;
            target_q <= hsp_rpm_q;
            lead_q   <= cfg_q.lead_hi;
            calc_q   <= C_IDLE;
          end else if (duty_span == 8'h00) begin
            stop_q   <= 1'b0;
            full_q   <= 1'b0;
            target_q <= lsp_rpm_q;
            lead_q   <= cfg_q.lead_lo;
            calc_q   <= C_IDLE;
          end else begin
            div_a_q     <= DW'(hsp_rpm_q - lsp_rpm_q) * DW'(duty_ofs);
            div_b_q     <= DW'(duty_span);
            div_start_q <= 1'b1;
            calc_q      <= C_SPD;
          end
        end
        C_SPD: begin
          if (div_done) begin
            stop_q      <= 1'b0;
            full_q      <= 1'b0;
            target_q    <= lsp_rpm_q + div_quot[RW-1:0];
            div_a_q     <= DW'(lead_span) * DW'(duty_ofs);
            div_b_q     <= DW'(duty_span);
            div_start_q <= 1'b1;
            calc_q      <= C_LEAD;
          end
        end
        C_LEAD: begin
          if (div_done) begin
            lead_q <= (cfg_q.lead_lo <= cfg_q.lead_hi) ? cfg_q.lead_lo + div_quot[7:0]
                                                       : cfg_q.lead_lo - div_quot[7:0];
            calc_q <= C_IDLE;
          end
        end
        default: calc_q <= C_IDLE;
      endcase
    end
  end

  // ---------------- bridge drive with dead time
  logic                 ctrl_en_q;
  logic [scc_pkg::CARRIER_W-1:0] car_cnt_q;
  logic [scc_pkg::CARRIER_W-1:0] car_thr;
  logic                 raw_on;
  logic                 run;
  logic                 on_q;
  logic                 phase_q;
  logic                 dt_act_q;
  logic [7:0]           dt_cnt_q;
  logic [7:0]           dt_len;
  scc_pkg::scc_gate_s   gate_q;

  assign car_thr = scc_pkg::CARRIER_W'((32'(duty_q) * scc_pkg::CARRIER_CYC) >> scc_pkg::DUTY_SHIFT);
  assign raw_on  = full_q | (car_cnt_q < car_thr);
  assign run     = ctrl_en_q & cfg_done & ~stop_q;
  assign dt_len  = cfg_q.softstart_deadtime_select_input[scc_pkg::CFG_DEAD_BIT] ? 8'(scc_pkg::DEAD_LONG_CYC)
                                                     : 8'(scc_pkg::DEAD_SHORT_CYC);

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      car_cnt_q <= '0;
    end else if (car_cnt_q == scc_pkg::CARRIER_W'(scc_pkg::CARRIER_CYC - 1)) begin
      car_cnt_q <= '0;
    end else begin
      car_cnt_q <= car_cnt_q + scc_pkg::CARRIER_W'(1);
    end
  end

  // every change of switched state passes through an all-off gap
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      on_q     <= 1'b0;
      phase_q  <= 1'b0;
      dt_act_q <= 1'b1;
      dt_cnt_q <= 8'(scc_pkg::DEAD_LONG_CYC);
    end else if (dt_act_q) begin
      if (dt_cnt_q == 8'h00) begin
        dt_act_q <= 1'b0;
        on_q     <= raw_on;
        phase_q  <= phase_select;
      end else begin
        dt_cnt_q <= dt_cnt_q - 8'h01;
      end
    end else if ((raw_on != on_q) || (phase_select != phase_q)) begin
      dt_act_q <= 1'b1;
      dt_cnt_q <= dt_len - 8'h01;
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      gate_q <= '0;
    end else if (!run || dt_act_q) begin
      gate_q <= '0;
    end else begin
      // active leg switches, its low side fills the off phase; idle leg low side on
      gate_q.leg1_hi <= ~phase_q & on_q;
      gate_q.leg1_lo <= phase_q | ~on_q;
      gate_q.leg2_hi <= phase_q & on_q;
      gate_q.leg2_lo <= ~phase_q | ~on_q;
    end
  end

  // ---------------- wishbone slave
  logic        ack_q;
  logic [31:0] rd_q;
  logic [31:0] rd_d;
  logic        wb_req;

  assign wb_req = wb_cyc_i & wb_stb_i & ~ack_q;

  always_comb begin
    rd_d = 32'h0000_0000;
    case ({wb_adr_i[7:2], 2'b00})
      scc_pkg::REG_CTRL:   rd_d[0] = ctrl_en_q;
      scc_pkg::REG_DUTY: begin
        rd_d[7:0]                      = duty_q;
        rd_d[scc_pkg::DUTY_STATIC_BIT] = static_q;
        rd_d[scc_pkg::DUTY_LEVEL_BIT]  = static_lvl_q;
      end
      scc_pkg::REG_TARGET: begin
        rd_d[RW-1:0]                = target_q;
        rd_d[scc_pkg::TGT_STOP_BIT] = stop_q;
        rd_d[scc_pkg::TGT_FULL_BIT] = full_q;
      end
      scc_pkg::REG_LEAD:   rd_d[7:0] = lead_q;
      scc_pkg::REG_CONFIG: begin
        rd_d[4:0]                   = cfg_q.softstart_deadtime_select_input;
        rd_d[scc_pkg::CFG_DONE_BIT] = cfg_done;
      end
      scc_pkg::REG_POINTS: rd_d = {hsp_rpm_q, lsp_rpm_q};
      default:             rd_d = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      ack_q     <= 1'b0;
      rd_q      <= '0;
      ctrl_en_q <= scc_pkg::CTRL_RESET;
    end else begin
      ack_q <= wb_req;
      if (wb_req) begin
        rd_q <= rd_d;
        if (wb_we_i && wb_sel_i[0] && ({wb_adr_i[7:2], 2'b00} == scc_pkg::REG_CTRL)) begin
          ctrl_en_q <= wb_dat_i[0];
        end
      end
    end
  end

  assign wb_ack_o          = ack_q;
  assign wb_dat_o          = rd_q;
  assign gate_drive        = gate_q;
  assign target_rpm        = target_q;
  assign lead_angle        = lead_q;
  assign motor_stop        = stop_q;
  assign full_drive        = full_q;
  assign softstart_pattern = cfg_q.softstart_deadtime_select_input[3:0];
  assign dead_time_long    = cfg_q.softstart_deadtime_select_input[scc_pkg::CFG_DEAD_BIT];
  assign config_done       = cfg_done;
endmodule
`default_nettype wire

// ===== sim/scc_host_model.sv
`timescale 1ns/100ps
`default_nettype none
module scc_host_model (
  input  wire logic ref_clk,
  input  wire logic run,
  input  wire logic lvl,
  input  var  int   hi,
  output var  logic pwm
);
  int n = 0;
  int h = 0;
  // new setting only at a period boundary, so no pulse is ever cut short
  always @(posedge ref_clk) begin
    n <= (n >= 255) ? 0 : n + 1;
    if (n >= 255) h <= run ? hi : (lvl ? 256 : 0);
    pwm <= n < h;
  end
endmodule
`default_nettype wire

// ===== sim/scc_speed_command_curve_checker.sv
`timescale 1ns/100ps
`default_nettype none
module scc_speed_command_curve_checker (
  input wire logic               ref_clk,
  input wire logic               arst_n,
  input wire logic               wb_cyc_i,
  input wire logic               wb_stb_i,
  input wire logic               wb_ack_o,
  input wire scc_pkg::scc_gate_s gate_drive,
  input wire logic               motor_stop,
  input wire logic               full_drive,
  input wire logic [3:0]         softstart_pattern,
  input wire logic               dead_time_long,
  input wire logic               config_done
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!arst_n);
  a_ack_next_cycle: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack missing");
  a_ack_one_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack too long");
  a_cfg_held: assert property (config_done |=> config_done && $stable(softstart_pattern)
    && $stable(dead_time_long)) else $error("setting changed");
  a_idle_before_cfg: assert property (!config_done |-> motor_stop && !full_drive
    && gate_drive == '0) else $error("active before config");
  a_no_shoot: assert property (!(gate_drive.leg1_hi && gate_drive.leg1_lo)
    && !(gate_drive.leg2_hi && gate_drive.leg2_lo)) else $error("shoot through");
  a_dead_gap: assert property ($fell(gate_drive.leg1_hi) |-> (gate_drive == '0)[*8])
    else $error("dead time short");
  a_stop_full_excl: assert property (!(motor_stop && full_drive))
    else $error("stop and full");
  a_stop_gates_off: assert property (motor_stop && $past(motor_stop) |-> gate_drive == '0)
    else $error("gates on while stopped");
endmodule
bind scc_speed_command_curve scc_speed_command_curve_checker u_chk (.ref_clk, .arst_n,
  .wb_cyc_i, .wb_stb_i, .wb_ack_o, .gate_drive, .motor_stop, .full_drive,
  .softstart_pattern, .dead_time_long, .config_done);
`default_nettype wire

// ===== sim/test_speed_command_curve.sv
`timescale 1ns/100ps
`default_nettype none
module test_speed_command_curve;
  logic ref_clk = 0, arst_n = 0, cyc = 0, we = 0, run = 0, lvl = 0, ph = 0;
  logic pwm, ack, stop, full, cdone, dtl;
  logic [7:0] adr = 0, lead;
  logic [15:0] rpm;
  logic [3:0] ssp, sel = 0;
  logic [31:0] wdat = 0, rd, wo, sd = 32'h16591468;
  scc_pkg::scc_settings_s st = '0, s;
  scc_pkg::scc_gate_s gd;
  int hi = 0, error_cnt = 0, n_tests = 0, i, d, lo_r, hi_r, dl, dh;
  always #2 ref_clk = ~ref_clk;
  scc_speed_command_curve #(.MEAS_TIMEOUT_CYC(2000)) u_dut (.ref_clk(ref_clk), .arst_n(arst_n),
    .pwm_command_input(pwm), .setting_inputs(st), .phase_select(ph), .wb_cyc_i(cyc),
    .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
    .wb_dat_o(wo), .wb_ack_o(ack), .gate_drive(gd), .target_rpm(rpm), .lead_angle(lead),
    .motor_stop(stop), .full_drive(full), .softstart_pattern(ssp), .dead_time_long(dtl),
    .config_done(cdone));
  scc_host_model u_host (.ref_clk(ref_clk), .run(run), .lvl(lvl), .hi(hi), .pwm(pwm));
  function automatic int rpm_of(int c);
    if (c <= 5) return 0;
    if (c < 73) return 400 + 10 * (c - 6);
    if (c < 148) return 1080 + 20 * (c - 73);
    if (c < 201) return 2600 + 50 * (c - 148);
    return 5300 + 100 * (c - 201);
  endfunction
  // straight line between the two points at the commanded duty
  function automatic int lerp(int a, int b);
    return a + (b - a) * (d - dl) / (dh - dl);
  endfunction
  function automatic logic [31:0] rnd();
    sd = sd ^ (sd << 13);
    sd = sd ^ (sd >> 17);
    sd = sd ^ (sd << 5);
    return sd;
  endfunction
  task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      $display("unexpected %s exp %0h got %0h", nm, e, g);
      error_cnt++;
    end
  endtask
  task automatic end_of_test();
    $display("errors %0d checks %0d", error_cnt, n_tests);
    if (error_cnt == 0 && n_tests > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic wb(logic w, logic [7:0] a, logic [31:0] dt = 0);
    int k;
    @(posedge ref_clk);
    cyc <= 1;
    we <= w;
    adr <= a;
    sel <= 4'h1;
    wdat <= dt;
    k = 0;
    do begin
      @(posedge ref_clk);
      k++;
    end while (ack !== 1'b1 && k < 20);
    rd = wo;
    cyc <= 0;
    if (k >= 20) begin
      error_cnt++;
      end_of_test();
    end
  endtask
  initial begin
    for (int r = 0; r < 4; r++) begin
      s.speed_a = 9'(6 + rnd() % 200);
      s.speed_b = 9'(s.speed_a + 1 + rnd() % 250);
      if (r == 0) {s.speed_a, s.speed_b} = {9'h005, 9'h1c0};
      s.duty_x = 8'(40 + rnd() % 60);
      s.duty_z = 8'(110 + rnd() % 90);
      {s.lead_lo, s.lead_hi, s.softstart_deadtime_select_input} = 21'(rnd());
      lo_r = rpm_of(s.speed_a);
      hi_r = rpm_of(s.speed_b);
      dl = s.duty_x;
      dh = s.duty_z;
      if (r[0]) {s.speed_a, s.speed_b} = {s.speed_b, s.speed_a};
      if (r[1]) {s.duty_x, s.duty_z} = {s.duty_z, s.duty_x};
      @(posedge ref_clk);
      arst_n <= 0;
      st <= s;
      ph <= r[0];
      run <= 0;
      lvl <= 0;
      repeat (3) @(posedge ref_clk);
      arst_n <= 1;
      i = 0;
      while (cdone !== 1'b1 && i < 400) begin
        @(posedge ref_clk);
        i++;
      end
      if (i >= 400) error_cnt++;
      if (i >= 400) end_of_test();
      chk("pattern", s.softstart_deadtime_select_input[3:0], ssp);
      chk("dead", s.softstart_deadtime_select_input[4], dtl);
      wb(0, 8'h14);
      chk("points", {16'(hi_r), 16'(lo_r)}, rd);
      for (int k = 0; k < 3; k++) begin
        d = (k == 0) ? dl - 10 : (k == 1) ? (dl + dh) / 2 : dh + 10;
        hi <= d;
        run <= 1;
        repeat (1300) @(posedge ref_clk);
        wb(0, 8'h04);
        chk("duty", d, rd[9:0]);
        if (k == 0 && r[0]) chk("stop", 1, stop);
        if (k == 0 && !r[0]) chk("low_rpm", lo_r, rpm);
        if (k == 1) chk("mid_rpm", lerp(lo_r, hi_r), rpm);
        if (k == 1) chk("lead", lerp(s.lead_lo, s.lead_hi), lead);
        if (k == 2 && r[1]) chk("full", 1, full);
        if (k == 2 && r[1]) chk("gates_full", ph ? 4'h6 : 4'h9, gd);
        if (k == 2 && !r[1]) chk("high_rpm", hi_r, rpm);
      end
      st <= 55'({rnd(), rnd()});
      run <= 0;
      lvl <= 1;
      repeat (4300) @(posedge ref_clk);
      wb(0, 8'h04);
      chk("static", 10'h3ff, rd[9:0]);
      chk("held", s.softstart_deadtime_select_input[3:0], ssp);
      wb(1, 8'h00, 0);
      wb(0, 8'h00);
      chk("ctrl", 0, rd[0]);
      chk("gates_off", 0, gd);
      wb(0, 8'h20);
      chk("unmapped", 0, rd);
    end
    end_of_test();
  end
endmodule
`default_nettype wire
